// >>> hdl/dbr_pkg.sv
// Package with constants and types for the burst request and termination block.
// Notes on behaviour
// - External request is detected on falling edge or on low level, as configured.
// - One request-accept pulse is given for the first sampling in every mode.
// - Single-address level burst inserts one uncounted dummy cycle without strobe first.
// - Second sampling starts in the first clock of the first real transfer.
// - Continued level requests add no more dummy cycles; sampling precedes each transfer.
// - A resumed single-address level burst starts again with one dummy cycle.
// - The acknowledge strobe covers each burst transfer as in cycle steal mode.
// - Edge dual-address burst samples once, then runs to count end without resampling.
// - Edge single-address burst adds one dummy cycle, then runs to count end.
// - Count reaching zero ends the channel, sets end flag, raises irq if enabled.
// - Clearing the channel enable halts without setting the end flag.
// - Interrupt or address-error flag stops after the current transfer; end flag stays clear.
// - In dual-address mode a flag raised during read waits for the write.
// - Clearing the master enable stops after the current transfer, as the channel enable does, without setting an end flag.
// - The interrupt-seen flag is set on every interrupt, even when idle.
// - Register access takes three clocks; longword splits into two word cycles back to back.
package dbr_pkg;
  localparam int          CNT_W         = 16;
  localparam logic [1:0]  START_LAT     = 2'h3;   // Cycles from sampling to first bus cycle.
  localparam logic [1:0]  PHASE_CYC     = 2'h3;   // Clocks per bus cycle, also register access.
  localparam logic [1:0]  PHASE_LAST    = 2'h2;   // Last clock index within a bus cycle.

  typedef enum logic [2:0] {
    DBR_IDLE  = 3'h0,
    DBR_WAIT  = 3'h1,
    DBR_DUMMY = 3'h2,
    DBR_READ  = 3'h3,
    DBR_XFER  = 3'h4
  } dbr_state_t;

  typedef enum logic [1:0] {
    DBR_RA_IDLE = 2'h0,
    DBR_RA_LO   = 2'h1,
    DBR_RA_HI   = 2'h2
  } dbr_ra_state_t;
endpackage

// >>> hdl/dbr_data_if.sv
// Interface carrying transfer words between the engine and its buffer.
`timescale 1ns/1ps
interface dbr_data_if;
  logic                     valid;
  logic                     ready;
  logic [dbr_pkg::CNT_W-1:0] data;
  modport src (output valid, output data, input ready);
  modport dst (input valid, input data, output ready);
endinterface

// >>> hdl/dbr_buf2.sv
// Two-entry buffer between the transfer engine and the data receiver.
`timescale 1ns/1ps
module dbr_buf2 (
  input  wire logic                      clk_sys,
  input  wire logic                      rst,
  input  wire logic                      clk_en,
  dbr_data_if.dst                        in_if,
  output logic                           out_valid,
  input  wire logic                      out_ready,
  output logic [dbr_pkg::CNT_W-1:0]      out_data
);
  logic [dbr_pkg::CNT_W-1:0] mem [2];
  logic       wp;
  logic       rp;
  logic [1:0] fill;
  wire        push = in_if.valid && in_if.ready;
  wire        pop  = out_valid && out_ready;

  // Ready reaches back to the engine, so a stalled receiver stalls transfers.
  assign in_if.ready = (fill != 2'h2);
  assign out_valid   = (fill != 2'h0);

  // Pointers and storage; the output word is registered.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wp   <= 1'b0;
      rp   <= 1'b0;
      fill <= 2'h0;
    end else if (clk_en) begin
      if (push) begin
        mem[wp] <= in_if.data;
        wp      <= ~wp;
      end
      if (pop) begin
        rp <= ~rp;
      end
      fill <= fill + {1'b0, push} - {1'b0, pop};
    end
  end

  // Registered read word so the data output comes from a flip-flop.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      out_data <= '0;
    end else if (clk_en) begin
      if (push && (fill == 2'h0 || (pop && fill == 2'h1))) begin
        out_data <= in_if.data;
      end else if (pop && fill == 2'h2) begin
        out_data <= mem[~rp];
      end
    end
  end
endmodule

// >>> hdl/dbr_engine.sv
// Request sampling, burst sequencing and ending conditions of one transfer channel.
`timescale 1ns/1ps
module dbr_engine (
  input  wire logic                      clk_sys,
  input  wire logic                      rst,
  input  wire logic                      clk_en,
  input  wire logic                      ext_transfer_request_n,
  input  wire logic                      edge_detect,
  input  wire logic                      single_addr,
  input  wire logic                      burst_mode,
  input  wire logic                      channel_enable_bit,
  input  wire logic                      master_enable_bit,
  input  wire logic                      end_irq_enable,
  input  wire logic                      count_load,
  input  wire logic [dbr_pkg::CNT_W-1:0] count_load_value,
  input  wire logic                      nmi_event,
  input  wire logic                      addr_error_event,
  input  wire logic                      nmi_clear,
  input  wire logic                      addr_error_clear,
  input  wire logic                      end_flag_clear,
  input  wire logic [dbr_pkg::CNT_W-1:0] xfer_data,
  input  wire logic                      reg_req,
  input  wire logic                      reg_long,
  output logic                           reg_word_strobe,
  output logic                           reg_done,
  output logic                           reg_busy,
  output logic                           data_valid,
  input  wire logic                      data_ready,
  output logic [dbr_pkg::CNT_W-1:0]      data_out,
  output logic                           request_accept_pulse,
  output logic                           transfer_ack_strobe,
  output logic                           dummy_cycle,
  output logic                           bus_busy,
  output logic [dbr_pkg::CNT_W-1:0]      transfer_count_reg,
  output logic [dbr_pkg::CNT_W-1:0]      source_address_reg,
  output logic [dbr_pkg::CNT_W-1:0]      dest_address_reg,
  output logic                           transfer_end_flag,
  output logic                           transfer_end_irq,
  output logic                           nmi_seen_flag,
  output logic                           addr_error_flag
);
  dbr_pkg::dbr_state_t    state;
  dbr_pkg::dbr_state_t    next_state;
  dbr_pkg::dbr_ra_state_t ra_state;
  logic [1:0] phase;
  logic [1:0] lat;
  logic [2:0] req_sync;
  logic       req_level;
  logic       req_prev;
  logic       resampled;
  dbr_data_if buf_if ();

  // Pin synchroniser: stage 0 feeds only stage 1; a change counts when stages 1 and 2 agree.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      req_sync  <= 3'h7;
      req_level <= 1'b1;
    end else if (clk_en) begin
      req_sync <= {req_sync[1:0], ext_transfer_request_n};
      if (req_sync[1] == req_sync[2]) begin
        req_level <= req_sync[2];
      end
    end
  end

  // Request decode; edge mode keys on a high-to-low change of the filtered level.
  wire req_fall   = req_prev && !req_level;
  wire req_seen   = edge_detect ? req_fall : !req_level;
  wire halt_flags = nmi_seen_flag || addr_error_flag;
  wire run_ok     = channel_enable_bit && master_enable_bit && !halt_flags;
  wire cycle_end  = (phase == dbr_pkg::PHASE_LAST);
  wire word_room  = buf_if.ready;
  wire last_xfer  = (transfer_count_reg == 16'h0001);
  wire count_zero = (transfer_count_reg == 16'h0000);
  // A dual-address read may only finish into its write, so the halt waits for the write.
  wire stop_now   = !run_ok && (state != dbr_pkg::DBR_READ);
  wire xfer_done  = (state == dbr_pkg::DBR_XFER) && cycle_end && word_room;
  wire do_dummy   = single_addr && burst_mode;
  // Level bursts sample in the first clock of each transfer; edge bursts never resample.
  wire sample_win = burst_mode && !edge_detect && (state == dbr_pkg::DBR_XFER)
                    && (phase == 2'h0);

  assign transfer_ack_strobe = (state == dbr_pkg::DBR_XFER);
  assign dummy_cycle         = (state == dbr_pkg::DBR_DUMMY);
  assign bus_busy            = (state != dbr_pkg::DBR_IDLE) && (state != dbr_pkg::DBR_WAIT);
  assign transfer_end_irq    = transfer_end_flag && end_irq_enable;

  // Next-state selection for the bus-cycle sequencer.
  always_comb begin
    next_state = state;
    unique case (state)
      dbr_pkg::DBR_IDLE: begin
        if (run_ok && !count_zero && req_seen) begin
          next_state = dbr_pkg::DBR_WAIT;
        end
      end
      dbr_pkg::DBR_WAIT: begin
        if (!run_ok) begin
          next_state = dbr_pkg::DBR_IDLE;
        end else if (lat == 2'h0) begin
          // The first bus cycle after a fresh start is a dummy in single-address burst.
          next_state = do_dummy ? dbr_pkg::DBR_DUMMY
                     : (single_addr ? dbr_pkg::DBR_XFER : dbr_pkg::DBR_READ);
        end
      end
      dbr_pkg::DBR_DUMMY: begin
        if (stop_now) begin
          next_state = dbr_pkg::DBR_IDLE;
        end else if (cycle_end) begin
          next_state = dbr_pkg::DBR_XFER;
        end
      end
      dbr_pkg::DBR_READ: begin
        if (cycle_end) begin
          next_state = dbr_pkg::DBR_XFER;
        end
      end
      dbr_pkg::DBR_XFER: begin
        if (xfer_done) begin
          if (last_xfer || !run_ok) begin
            next_state = dbr_pkg::DBR_IDLE;
          end else if (burst_mode && (edge_detect || resampled)) begin
            next_state = single_addr ? dbr_pkg::DBR_XFER : dbr_pkg::DBR_READ;
          end else begin
            next_state = dbr_pkg::DBR_IDLE;
          end
        end
      end
    endcase
  end

  // Sequencer registers: state, phase within a bus cycle and start latency.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state    <= dbr_pkg::DBR_IDLE;
      phase    <= 2'h0;
      lat      <= 2'h0;
      req_prev <= 1'b1;
    end else if (clk_en) begin
      state    <= next_state;
      req_prev <= req_level;
      if (next_state != state || cycle_end) begin
        phase <= 2'h0;
      end else if (state != dbr_pkg::DBR_XFER || !cycle_end) begin
        phase <= phase + 2'h1;
      end
      if (state == dbr_pkg::DBR_IDLE) begin
        lat <= dbr_pkg::START_LAT - 2'h1;
      end else if (lat != 2'h0) begin
        lat <= lat - 2'h1;
      end
    end
  end

  // The accept pulse marks the first sampling only, whatever the mode.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      request_accept_pulse <= 1'b0;
      resampled            <= 1'b0;
    end else if (clk_en) begin
      request_accept_pulse <= (next_state == dbr_pkg::DBR_WAIT)
                              && (state == dbr_pkg::DBR_IDLE);
      if (sample_win) begin
        resampled <= !req_level;
      end else if (xfer_done) begin
        resampled <= 1'b0;
      end
    end
  end

  // Count, address and end flag; a dummy cycle never touches the count.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      transfer_count_reg <= '0;
      source_address_reg <= '0;
      dest_address_reg   <= '0;
      transfer_end_flag  <= 1'b0;
    end else if (clk_en) begin
      if (count_load) begin
        transfer_count_reg <= count_load_value;
      end else if (xfer_done) begin
        transfer_count_reg <= transfer_count_reg - 16'h0001;
        source_address_reg <= source_address_reg + 16'h0001;
        dest_address_reg   <= dest_address_reg + 16'h0001;
      end
      // The set wins over a simultaneous clear, so no ending is lost.
      if (xfer_done && last_xfer) begin
        transfer_end_flag <= 1'b1;
      end else if (end_flag_clear) begin
        transfer_end_flag <= 1'b0;
      end
    end
  end

  // Global flags are set by the event at any time, transfer or not.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      nmi_seen_flag   <= 1'b0;
      addr_error_flag <= 1'b0;
    end else if (clk_en) begin
      if (nmi_event) begin
        nmi_seen_flag <= 1'b1;
      end else if (nmi_clear) begin
        nmi_seen_flag <= 1'b0;
      end
      if (addr_error_event) begin
        addr_error_flag <= 1'b1;
      end else if (addr_error_clear) begin
        addr_error_flag <= 1'b0;
      end
    end
  end

  // Register access timing: each word cycle lasts three clocks, a long is two in a row.
  logic [1:0] ra_cnt;
  logic       reg_long_q;
  wire        ra_last = (ra_cnt == dbr_pkg::PHASE_LAST);
  assign reg_busy        = (ra_state != dbr_pkg::DBR_RA_IDLE);
  assign reg_word_strobe = reg_busy && ra_last;
  assign reg_done        = reg_word_strobe && (ra_state == dbr_pkg::DBR_RA_HI
                                               || !reg_long_q);
  // Register access sequencer; a long access holds the second word right behind the first.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ra_state   <= dbr_pkg::DBR_RA_IDLE;
      ra_cnt     <= 2'h0;
      reg_long_q <= 1'b0;
    end else if (clk_en) begin
      unique case (ra_state)
        dbr_pkg::DBR_RA_IDLE: begin
          if (reg_req) begin
            ra_state   <= dbr_pkg::DBR_RA_LO;
            reg_long_q <= reg_long;
            ra_cnt     <= 2'h0;
          end
        end
        dbr_pkg::DBR_RA_LO: begin
          ra_cnt <= ra_last ? 2'h0 : ra_cnt + 2'h1;
          if (ra_last) begin
            ra_state <= reg_long_q ? dbr_pkg::DBR_RA_HI : dbr_pkg::DBR_RA_IDLE;
          end
        end
        dbr_pkg::DBR_RA_HI: begin
          ra_cnt <= ra_last ? 2'h0 : ra_cnt + 2'h1;
          if (ra_last) begin
            ra_state <= dbr_pkg::DBR_RA_IDLE;
          end
        end
        default: ra_state <= dbr_pkg::DBR_RA_IDLE;
      endcase
    end
  end

  // Transfer words go through the two-entry buffer; a full buffer holds the transfer.
  assign buf_if.valid = xfer_done;
  assign buf_if.data  = xfer_data;

  dbr_buf2 u_buf (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .clk_en    (clk_en),
    .in_if     (buf_if.dst),
    .out_valid (data_valid),
    .out_ready (data_ready),
    .out_data  (data_out)
  );

  AST_DUMMY_NO_ACK: assert property (@(posedge clk_sys) disable iff (rst)
    dummy_cycle |-> !transfer_ack_strobe) else $error("Strobe during dummy cycle.");
  AST_DUMMY_NO_COUNT: assert property (@(posedge clk_sys) disable iff (rst)
    (clk_en && dummy_cycle && !count_load) |=> $stable(transfer_count_reg))
    else $error("Count moved in dummy cycle.");
  AST_ACCEPT_ONCE: assert property (@(posedge clk_sys) disable iff (rst)
    (clk_en && request_accept_pulse) |=> !request_accept_pulse) else $error("Accept pulse too long.");
  AST_START_LAT: assert property (@(posedge clk_sys) disable iff (rst)
    request_accept_pulse |-> (!bus_busy) [*3]) else $error("Bus cycle before start latency.");
  AST_END_FLAG: assert property (@(posedge clk_sys) disable iff (rst)
    (clk_en && xfer_done && last_xfer) |=> transfer_end_flag) else $error("End flag missing.");
  AST_DE_NO_END: assert property (@(posedge clk_sys) disable iff (rst)
    (clk_en && !channel_enable_bit && !xfer_done && !transfer_end_flag) |=> !transfer_end_flag)
    else $error("End flag set by disable.");
  AST_NMI_SET: assert property (@(posedge clk_sys) disable iff (rst)
    (clk_en && nmi_event) |=> nmi_seen_flag) else $error("Interrupt flag not set.");
  AST_HALT_STOP: assert property (@(posedge clk_sys) disable iff (rst)
    (clk_en && halt_flags && state == dbr_pkg::DBR_IDLE) |=> state == dbr_pkg::DBR_IDLE)
    else $error("Started while halted.");
  AST_READ_TO_WRITE: assert property (@(posedge clk_sys) disable iff (rst)
    (clk_en && state == dbr_pkg::DBR_READ && cycle_end) |=> state == dbr_pkg::DBR_XFER)
    else $error("Read not followed by write.");
  AST_DME_ABORT: assert property (@(posedge clk_sys) disable iff (rst)
    (clk_en && !master_enable_bit
     && (state == dbr_pkg::DBR_WAIT || state == dbr_pkg::DBR_DUMMY))
    |=> state == dbr_pkg::DBR_IDLE)
    else $error("Master disable did not abort.");
  AST_LONG_SPLIT: assert property (@(posedge clk_sys) disable iff (rst)
    (clk_en && reg_word_strobe && ra_state == dbr_pkg::DBR_RA_LO && reg_long_q)
    |=> reg_busy) else $error("Gap in longword access.");
  COV_DUMMY: cover property (@(posedge clk_sys) dummy_cycle ##1 transfer_ack_strobe);
  COV_END: cover property (@(posedge clk_sys) transfer_end_flag);
  COV_LONG: cover property (@(posedge clk_sys) reg_done && reg_long_q);
endmodule

// >>> tb/dbr_requester.sv
// Far-side model: the external requester on the request pin and the word receiver.
`timescale 1ns/1ps
module dbr_requester (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic want,
  input  wire logic edge_mode,
  input  wire logic request_accept_pulse,
  output logic      ext_transfer_request_n,
  output logic      data_ready
);
  integer seed = 1;
  logic   taken = 1'b0;
  initial data_ready = 1'b0;
  // An edge requester lets go after the accept pulse and rearms only when want drops.
  // The receiver stalls on about a quarter of the cycles to exercise the buffer.
  always @(posedge clk_sys) begin
    if (rst || !want) taken <= #2 1'b0;
    else if (request_accept_pulse && edge_mode) taken <= #2 1'b1;
    data_ready <= #2 (($random(seed) & 3) != 0);
  end
  // The pin rests high whenever no request is wanted, so configuring sees no edge.
  assign ext_transfer_request_n = !(want && !taken);
endmodule

// >>> tb/dbr_engine_tb.sv
// Self-checking bench for the burst request and termination engine.
`timescale 1ns/1ps
module dbr_engine_tb;
  localparam int W = dbr_pkg::CNT_W;
  logic         clk_sys = 1'b0;
  logic         rst = 1'b1;
  logic         clk_en = 1'b1;
  logic         gate = 1'b0;
  logic         edge_detect = 1'b0;
  logic         single_addr = 1'b0;
  logic         burst_mode = 1'b1;
  logic         channel_enable_bit = 1'b0;
  logic         master_enable_bit = 1'b1;
  logic         end_irq_enable = 1'b0;
  logic         count_load = 1'b0;
  logic [W-1:0] count_load_value = 16'h0;
  logic         nmi_event = 1'b0;
  logic         addr_error_event = 1'b0;
  logic         nmi_clear = 1'b0;
  logic         addr_error_clear = 1'b0;
  logic         end_flag_clear = 1'b0;
  logic [W-1:0] xfer_data;
  logic         reg_req = 1'b0;
  logic         reg_long = 1'b0;
  logic         want = 1'b0;
  logic         ext_transfer_request_n, data_ready, reg_word_strobe, reg_done, reg_busy;
  logic         data_valid, request_accept_pulse, transfer_ack_strobe, dummy_cycle, bus_busy;
  logic         transfer_end_flag, transfer_end_irq, nmi_seen_flag, addr_error_flag;
  logic [W-1:0] data_out, transfer_count_reg, source_address_reg, dest_address_reg;
  logic [W-1:0] exp_data = 16'h0;
  logic [W-1:0] src0 = 16'h0;
  logic         dummy_q = 1'b0;
  integer       seed = 1;
  int           num_errors = 0;
  int           num_checks = 0;
  int           cyc = 0, accepts = 0, dummies = 0, words = 0, cnt_base = 0;
  int           wstrobes = 0, dones = 0, wgap = 0, wlast = 0;

  dbr_engine i_dut (
    .clk_sys, .rst, .clk_en, .ext_transfer_request_n, .edge_detect, .single_addr,
    .burst_mode, .channel_enable_bit, .master_enable_bit, .end_irq_enable, .count_load,
    .count_load_value, .nmi_event, .addr_error_event, .nmi_clear, .addr_error_clear,
    .end_flag_clear, .xfer_data, .reg_req, .reg_long, .reg_word_strobe, .reg_done, .reg_busy,
    .data_valid, .data_ready, .data_out, .request_accept_pulse, .transfer_ack_strobe,
    .dummy_cycle, .bus_busy, .transfer_count_reg, .source_address_reg, .dest_address_reg,
    .transfer_end_flag, .transfer_end_irq, .nmi_seen_flag, .addr_error_flag
  );
  dbr_requester i_req (
    .clk_sys, .rst, .want, .edge_mode(edge_detect), .request_accept_pulse,
    .ext_transfer_request_n, .data_ready
  );

  // Each word carries the count it left at, so the buffer's order is checked as well.
  assign xfer_data = exp_data ^ transfer_count_reg;

  // While gated, the clock enable drops on about a quarter of the cycles to test freezing.
  always @(posedge clk_sys) clk_en <= #2 !gate || (($random(seed) & 3) != 0);

  // The 40 MHz system clock.
  always #12.5 clk_sys = ~clk_sys;

  task automatic check(input string name, input logic [W-1:0] seen, input logic [W-1:0] expv);
    num_checks++;
    if (seen !== expv) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", name, expv, seen);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d, errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Monitors count events every edge; totals are judged once a run has drained.
  // The timeout is generous: the whole sequence needs only a few thousand cycles.
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    dummy_q <= dummy_cycle;
    if (request_accept_pulse === 1'b1 && clk_en === 1'b1) accepts <= accepts + 1;
    if (dummy_cycle === 1'b1 && dummy_q !== 1'b1) dummies <= dummies + 1;
    if (dummy_cycle === 1'b1) check("dummy_ack", 16'(transfer_ack_strobe), 16'h0);
    if (reg_done === 1'b1) dones <= dones + 1;
    if (reg_word_strobe === 1'b1) begin
      wstrobes <= wstrobes + 1;
      wgap <= cyc - wlast;
      wlast <= cyc;
    end
    if (data_valid === 1'b1 && data_ready === 1'b1 && clk_en === 1'b1) begin
      words <= words + 1;
      check("data_out", data_out, exp_data ^ 16'(cnt_base - words));
    end
    if (cyc == 30000) begin
      num_errors++;
      report_and_stop();
    end
  end

  // Inputs always move 2 ns after a rising edge.
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask

  function automatic int exp_dummies(input logic s, input int resumes);
    return s ? 1 + resumes : 0;
  endfunction

  function automatic logic exp_irq(input logic f, input logic en);
    return f & en;
  endfunction

  task automatic load(input int n);
    count_load_value = 16'(n);
    count_load = 1'b1;
    step(1);
    count_load = 1'b0;
  endtask

  // Configuration with the pin high, channel enable written last, then the request.
  task automatic setup(input logic e, input logic s, input int n);
    edge_detect = e;
    single_addr = s;
    exp_data = 16'($random(seed));
    cnt_base = n;
    src0 = source_address_reg;
    end_irq_enable = 1'($random(seed));
    load(n);
    accepts = 0;
    dummies = 0;
    words = 0;
    channel_enable_bit = 1'b1;
    step(1);
    want = 1'b1;
  endtask

  task automatic finish(input int n, input logic s, input logic e, input int r);
    for (int i = 0; i < 400 && transfer_end_flag !== 1'b1; i++) step(1);
    gate = 1'b0;
    want = 1'b0;
    step(12);
    check("end_flag", 16'(transfer_end_flag), 16'h1);
    check("count", transfer_count_reg, 16'h0);
    check("end_irq", 16'(transfer_end_irq), 16'(exp_irq(1'b1, end_irq_enable)));
    check("words", 16'(words), 16'(n));
    check("dummies", 16'(dummies), 16'(exp_dummies(s & burst_mode, r)));
    check("src_moved", source_address_reg - src0, 16'(n));
    check("dst_moved", dest_address_reg - src0, 16'(n));
    if (e) check("accepts", 16'(accepts), 16'(1 + r));
    channel_enable_bit = 1'b0;
    end_flag_clear = 1'b1;
    load(0);
    end_flag_clear = 1'b0;
    step(1);
    check("end_cleared", 16'(transfer_end_flag), 16'h0);
    $display("test done: edge %0d single %0d count %0d resumes %0d", e, s, n, r);
  endtask

  // Kinds: 0 interrupt flag, 1 address error, 2 channel enable off, 3 master enable off.
  task automatic halt(input int k, input logic e, input logic s);
    setup(e, s, 8);
    for (int i = 0; i < 60 && bus_busy !== 1'b1; i++) step(1);
    nmi_event = (k == 0);
    addr_error_event = (k == 1);
    if (k == 2) channel_enable_bit = 1'b0;
    if (k == 3) master_enable_bit = 1'b0;
    step(1);
    nmi_event = 1'b0;
    addr_error_event = 1'b0;
    step(40);
    check("halt_end_flag", 16'(transfer_end_flag), 16'h0);
    check("halt_bus", 16'(bus_busy), 16'h0);
    if (k < 2) begin
      check("halt_count", transfer_count_reg, 16'(8 - words));
      check("halt_src", source_address_reg - src0, 16'(words));
      check("halt_flag", 16'(k == 0 ? nmi_seen_flag : addr_error_flag), 16'h1);
      nmi_clear = 1'b1;
      addr_error_clear = 1'b1;
      want = 1'b0;
      step(1);
      nmi_clear = 1'b0;
      addr_error_clear = 1'b0;
      step(2);
      want = 1'b1;
      finish(8, s, e, 1);
    end else begin
      check("halt_left", 16'(transfer_count_reg != 16'h0), 16'h1);
      want = 1'b0;
      master_enable_bit = 1'b1;
      channel_enable_bit = 1'b0;
      load(0);
      $display("test done: abort kind %0d", k);
    end
  endtask

  // Main sequence: reset, idle flag, refusal, mode table, random runs, halts, registers.
  initial begin
    int   n;
    logic e;
    logic s;
    step(5);
    rst = 1'b0;
    step(1);
    check("rst_count", transfer_count_reg, 16'h0);
    check("rst_src", source_address_reg, 16'h0);
    check("rst_dst", dest_address_reg, 16'h0);
    check("rst_flags", 16'({transfer_end_flag, nmi_seen_flag, addr_error_flag, data_valid}), 16'h0);
    step(4);
    nmi_event = 1'b1;
    step(1);
    nmi_event = 1'b0;
    step(2);
    check("idle_nmi", 16'(nmi_seen_flag), 16'h1);
    nmi_clear = 1'b1;
    step(1);
    nmi_clear = 1'b0;
    step(1);
    check("nmi_cleared", 16'(nmi_seen_flag), 16'h0);
    $display("test done: reset and idle flag");
    setup(1'b0, 1'b0, 0);
    step(30);
    check("zero_accepts", 16'(accepts), 16'h0);
    want = 1'b0;
    channel_enable_bit = 1'b0;
    $display("test done: zero count refused");
    for (int m = 0; m < 5; m++) begin
      burst_mode = (m != 4);
      setup(m[1], m[0], 3);
      finish(3, m[0], m[1], 0);
    end
    burst_mode = 1'b1;
    for (int i = 0; i < 6; i++) begin
      e = 1'($random(seed));
      s = 1'($random(seed));
      n = 1 + ($random(seed) & 7);
      setup(e, s, n);
      gate = 1'b1;
      finish(n, s, e, 0);
    end
    halt(0, 1'b1, 1'b0);
    halt(0, 1'b1, 1'b1);
    halt(1, 1'b0, 1'b1);
    halt(2, 1'b0, 1'b0);
    halt(3, 1'b1, 1'b1);
    for (int l = 0; l < 2; l++) begin
      reg_long = l[0];
      wstrobes = 0;
      dones = 0;
      reg_req = 1'b1;
      step(1);
      reg_req = 1'b0;
      step(10);
      check("reg_words", 16'(wstrobes), 16'(l + 1));
      check("reg_done", 16'(dones), 16'h1);
      check("reg_busy", 16'(reg_busy), 16'h0);
      if (l == 1) check("reg_gap", 16'(wgap), 16'(dbr_pkg::PHASE_CYC));
      $display("test done: register access long %0d", l);
    end
    master_enable_bit = 1'b0;
    step(2);
    check("standby_idle", 16'(bus_busy), 16'h0);
    report_and_stop();
  end
endmodule
